/* design/iep_pkg.sv */
package iep_pkg;
  // register addresses and widths
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam logic [3:0] OFF_ENABLE = 4'h0;
  localparam logic [3:0] OFF_PRIORITY = 4'h1;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h2;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h3;
  localparam logic [3:0] OFF_REQ_VIEW = 4'h4;
  // enable register layout
  localparam logic [15:0] ENABLE_IMPL_MASK = 16'h00F6;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam int unsigned EN_UART_A_ERR = 1;
  localparam int unsigned EN_UART_B_ERR = 2;
  localparam int unsigned EN_DMA_CH6 = 4;
  localparam int unsigned EN_DMA_CH7 = 5;
  localparam int unsigned EN_CAN_A_TX = 6;
  localparam int unsigned EN_CAN_B_TX = 7;
  // priority register layout
  localparam int unsigned PRI_EXT0_LSB = 0;
  localparam int unsigned PRI_INCAP_LSB = 4;
  localparam int unsigned PRI_OUTCMP_LSB = 8;
  localparam int unsigned PRI_TIMER_LSB = 12;
  localparam logic [15:0] PRIORITY_IMPL_MASK = 16'h7777;
  localparam logic [15:0] PRIORITY_RESET = 16'h4444;
  localparam logic [2:0] LEVEL_DISABLED = 3'h0;
  // request indices: six gated sources then four prioritised sources
  localparam int unsigned NUM_GATED = 6;
  localparam int unsigned NUM_PRIO = 4;
  localparam logic [15:0] IRQ_STATUS_RESET = 16'h0000;
  localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;
endpackage

/* design/iep_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module iep_gate #(
  parameter int unsigned N = 6
) (
  input wire logic [N-1:0] i_flag,
  input wire logic [N-1:0] i_enable,
  output logic [N-1:0] o_req
);
  assign o_req = i_flag & i_enable;
endmodule
`default_nettype wire

/* design/iep_level.sv */
`timescale 1ns/1ps
`default_nettype none
module iep_level (
  input wire logic i_flag,
  input wire logic [2:0] i_level,
  output logic o_req,
  output logic [2:0] o_level
);
  // level code is the priority number itself
  assign o_level = i_level;
  assign o_req = i_flag && (i_level != iep_pkg::LEVEL_DISABLED);
endmodule
`default_nettype wire

/* design/iep_slice.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - enable bits 15-8, 3 and 0 read zero and ignore writes
// - enable bit 7 gates second CAN transmit request
// - enable bit 6 gates first CAN transmit request
// - enable bit 5 gates DMA channel 7 completion
// - enable bit 4 gates DMA channel 6 completion
// - enable bit 2 gates second UART error
// - enable bit 1 gates first UART error
// - enable one passes request, zero blocks it
// - implemented enable bits read/write, reset to zero
// - timer priority field at bits 14-12
// - priority code equals level, 7 highest, 1 lowest
// - output-compare priority field at bits 10-8
// - input-capture priority field at bits 6-4
// - external pin 0 priority field at bits 2-0
// - priority zero disables source regardless of enable
module iep_slice
  import iep_pkg::*;
(
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // register port
  input wire logic [iep_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [iep_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [iep_pkg::DATA_W-1:0] O_RDATA,
  // peripheral request flags
  input wire logic I_CAN_B_TX_FLAG,
  input wire logic I_CAN_A_TX_FLAG,
  input wire logic I_DMA_CH7_FLAG,
  input wire logic I_DMA_CH6_FLAG,
  input wire logic I_UART_B_ERR_FLAG,
  input wire logic I_UART_A_ERR_FLAG,
  input wire logic I_TIMER_A_FLAG,
  input wire logic I_OUTCMP_A_FLAG,
  input wire logic I_INCAP_A_FLAG,
  input wire logic I_EXT_PIN0_FLAG,
  // requests to processor arbitration
  output logic [iep_pkg::NUM_GATED-1:0] O_GATED_REQ,
  output logic [iep_pkg::NUM_PRIO-1:0] O_PRIO_REQ,
  output logic [11:0] O_PRIO_LEVEL,
  // interrupt
  output logic O_IRQ
);
  logic [15:0] enable_q, enable_d;
  logic [15:0] priority_q, priority_d;
  logic [15:0] irq_status_q, irq_status_d;
  logic [15:0] irq_mask_q, irq_mask_d;
  logic [15:0] rdata_q, rdata_d;
  logic [NUM_GATED-1:0] gated_q, gated_d;
  logic [NUM_PRIO-1:0] prio_req_q, prio_req_d;
  logic [11:0] prio_level_q, prio_level_d;
  logic irq_q, irq_d;
  logic [NUM_GATED-1:0] gated_flag, gated_en, gated_now;
  logic [NUM_PRIO-1:0] prio_flag, prio_now;
  logic [11:0] level_now;
  logic [15:0] events;

  // gated source order: uart a, uart b, dma6, dma7, can a, can b
  assign gated_flag = {I_CAN_B_TX_FLAG, I_CAN_A_TX_FLAG, I_DMA_CH7_FLAG,
                       I_DMA_CH6_FLAG, I_UART_B_ERR_FLAG, I_UART_A_ERR_FLAG};
  assign gated_en = {enable_q[EN_CAN_B_TX],
                     enable_q[EN_CAN_A_TX],
                     enable_q[EN_DMA_CH7],
                     enable_q[EN_DMA_CH6],
                     enable_q[EN_UART_B_ERR],
                     enable_q[EN_UART_A_ERR]};

  iep_gate #(
    .N(NUM_GATED)
  ) u_gate (
    .i_flag(gated_flag),
    .i_enable(gated_en),
    .o_req(gated_now)
  );

  // prioritised order: ext pin 0, input capture, output compare, timer
  assign prio_flag = {I_TIMER_A_FLAG, I_OUTCMP_A_FLAG, I_INCAP_A_FLAG, I_EXT_PIN0_FLAG};

  iep_level u_lvl_ext0 (
    .i_flag(prio_flag[0]),
    .i_level(priority_q[PRI_EXT0_LSB +: 3]),
    .o_req(prio_now[0]),
    .o_level(level_now[2:0])
  );
  iep_level u_lvl_incap (
    .i_flag(prio_flag[1]),
    .i_level(priority_q[PRI_INCAP_LSB +: 3]),
    .o_req(prio_now[1]),
    .o_level(level_now[5:3])
  );
  iep_level u_lvl_outcmp (
    .i_flag(prio_flag[2]),
    .i_level(priority_q[PRI_OUTCMP_LSB +: 3]),
    .o_req(prio_now[2]),
    .o_level(level_now[8:6])
  );
  iep_level u_lvl_timer (
    .i_flag(prio_flag[3]),
    .i_level(priority_q[PRI_TIMER_LSB +: 3]),
    .o_req(prio_now[3]),
    .o_level(level_now[11:9])
  );

  // sticky status captures presented requests, bits 5:0 gated, 9:6 prioritised
  assign events = {6'h00, prio_now, gated_now};

  always_comb begin
    enable_d = enable_q;
    priority_d = priority_q;
    irq_mask_d = irq_mask_q;
    irq_status_d = irq_status_q;
    rdata_d = 16'h0000;
    if (I_WR) begin
      unique case (I_ADDR)
        OFF_ENABLE: enable_d = I_WDATA & ENABLE_IMPL_MASK;
        OFF_PRIORITY: priority_d = I_WDATA & PRIORITY_IMPL_MASK;
        OFF_IRQ_MASK: irq_mask_d = I_WDATA & 16'h03FF;
        OFF_IRQ_STATUS: irq_status_d = irq_status_q & ~I_WDATA;
        default: ;
      endcase
    end
    // set wins over a same-cycle clear
    irq_status_d = irq_status_d | events;
    if (I_RD) begin
      unique case (I_ADDR)
        OFF_ENABLE: rdata_d = enable_q;
        OFF_PRIORITY: rdata_d = priority_q;
        OFF_IRQ_STATUS: rdata_d = irq_status_q;
        OFF_IRQ_MASK: rdata_d = irq_mask_q;
        OFF_REQ_VIEW: rdata_d = {6'h00, prio_req_q, gated_q};
        default: rdata_d = 16'h0000;
      endcase
    end
    gated_d = gated_now;
    prio_req_d = prio_now;
    prio_level_d = level_now;
    irq_d = |(irq_status_d & irq_mask_d);
  end

  // outputs are registered, so requests reach the processor one cycle late
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      enable_q <= ENABLE_RESET;
      priority_q <= PRIORITY_RESET;
      irq_status_q <= IRQ_STATUS_RESET;
      irq_mask_q <= IRQ_MASK_RESET;
      rdata_q <= 16'h0000;
      gated_q <= '0;
      prio_req_q <= '0;
      prio_level_q <= 12'h000;
      irq_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
      priority_q <= priority_d;
      irq_status_q <= irq_status_d;
      irq_mask_q <= irq_mask_d;
      rdata_q <= rdata_d;
      gated_q <= gated_d;
      prio_req_q <= prio_req_d;
      prio_level_q <= prio_level_d;
      irq_q <= irq_d;
    end
  end

  assign O_RDATA = rdata_q;
  assign O_GATED_REQ = gated_q;
  assign O_PRIO_REQ = prio_req_q;
  assign O_PRIO_LEVEL = prio_level_q;
  assign O_IRQ = irq_q;
endmodule
`default_nettype wire

/* sim/iep_src.sv */
`timescale 1ns/1ps
`default_nettype none
module iep_src (
  // clock
  input wire logic i_clk,
  // wanted flag pattern
  input wire logic [9:0] i_set,
  // peripheral flag levels
  output logic [9:0] o_flag
);
  logic [9:0] flag_d;
  // peripherals raise a level one edge after being told
  always_comb flag_d = i_set;
  always_ff @(posedge i_clk) o_flag <= flag_d;
endmodule
`default_nettype wire

/* sim/iep_slice_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module iep_slice_chk
  import iep_pkg::*;
(
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // register port
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [DATA_W-1:0] O_RDATA,
  // flags
  input wire logic I_CAN_B_TX_FLAG,
  input wire logic I_CAN_A_TX_FLAG,
  input wire logic I_DMA_CH7_FLAG,
  input wire logic I_DMA_CH6_FLAG,
  input wire logic I_UART_B_ERR_FLAG,
  input wire logic I_UART_A_ERR_FLAG,
  input wire logic I_TIMER_A_FLAG,
  // requests
  input wire logic [NUM_GATED-1:0] O_GATED_REQ,
  input wire logic [NUM_PRIO-1:0] O_PRIO_REQ,
  input wire logic [11:0] O_PRIO_LEVEL
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  logic [15:0] en_q, en_d;
  logic [5:0] g, e;
  logic [3:0] nz;
  logic [11:0] w;
  // shadow of the enable register, kept from bus writes only
  always_comb begin
    en_d = en_q;
    if (I_WR && I_ADDR == OFF_ENABLE) en_d = I_WDATA & ENABLE_IMPL_MASK;
    if (I_RST) en_d = ENABLE_RESET;
  end
  always_ff @(posedge I_CLK_SYS) en_q <= en_d;
  assign g = {I_CAN_B_TX_FLAG, I_CAN_A_TX_FLAG, I_DMA_CH7_FLAG, I_DMA_CH6_FLAG,
    I_UART_B_ERR_FLAG, I_UART_A_ERR_FLAG};
  assign e = {en_q[7:4], en_q[2:1]};
  assign nz = {|O_PRIO_LEVEL[11:9], |O_PRIO_LEVEL[8:6], |O_PRIO_LEVEL[5:3], |O_PRIO_LEVEL[2:0]};
  assign w = {I_WDATA[14:12], I_WDATA[10:8], I_WDATA[6:4], I_WDATA[2:0]};
  a_en_readback: assert property (
    $past(I_RD && I_ADDR == OFF_ENABLE) |-> O_RDATA == $past(en_q)) else $error("enable readback");
  a_pri_unused: assert property (
    $past(I_RD && I_ADDR == OFF_PRIORITY) |-> (O_RDATA & 16'h8888) == 16'h0000)
    else $error("priority spare bits set");
  a_gate_can: assert property (
    O_GATED_REQ[5:4] == $past(g[5:4] & e[5:4])) else $error("can gating");
  a_gate_dma: assert property (
    O_GATED_REQ[3:2] == $past(g[3:2] & e[3:2])) else $error("dma gating");
  a_gate_uart: assert property (
    O_GATED_REQ[1:0] == $past(g[1:0] & e[1:0])) else $error("uart gating");
  a_prio_off: assert property (
    (O_PRIO_REQ & ~nz) == 4'h0) else $error("request at level zero");
  a_timer_flag: assert property (
    O_PRIO_REQ[3] |-> $past(I_TIMER_A_FLAG)) else $error("timer request without flag");
  a_level_map: assert property (
    $past(I_WR && I_ADDR == OFF_PRIORITY, 2) |-> O_PRIO_LEVEL == $past(w, 2))
    else $error("level fields");
endmodule
bind iep_slice iep_slice_chk i_chk (.*);
`default_nettype wire

/* sim/iep_slice_test.sv */
`timescale 1ns/1ps
`default_nettype none
module iep_slice_test;
  import iep_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, irq;
  logic [3:0] addr = 4'h0, preq;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [9:0] set = 10'h000, flag;
  logic [5:0] greq;
  logic [11:0] lvl;
  logic [2:0] c3;
  int error_cnt = 0, n_tests = 0;
  always #2.5 clk = ~clk;
  iep_src i_src (.i_clk(clk), .i_set(set), .o_flag(flag));
  iep_slice i_dut (.I_CLK_SYS(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_CAN_B_TX_FLAG(flag[5]), .I_CAN_A_TX_FLAG(flag[4]),
    .I_DMA_CH7_FLAG(flag[3]), .I_DMA_CH6_FLAG(flag[2]), .I_UART_B_ERR_FLAG(flag[1]),
    .I_UART_A_ERR_FLAG(flag[0]), .I_TIMER_A_FLAG(flag[9]), .I_OUTCMP_A_FLAG(flag[8]),
    .I_INCAP_A_FLAG(flag[7]), .I_EXT_PIN0_FLAG(flag[6]), .O_GATED_REQ(greq),
    .O_PRIO_REQ(preq), .O_PRIO_LEVEL(lvl), .O_IRQ(irq));
  task automatic final_report;
    if (error_cnt == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrt(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // flags pass the model and the output register before they are looked at
  task automatic src(input logic [9:0] v);
    @(posedge clk);
    set <= v;
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc(OFF_ENABLE, ENABLE_RESET);
    rdc(OFF_PRIORITY, 16'h4444);
    wrt(OFF_ENABLE, 16'hFFFF);
    rdc(OFF_ENABLE, 16'h00F6);
    for (int k = 0; k < 6; k++) begin
      wrt(OFF_ENABLE, 16'h0001 << (k < 2 ? k + 1 : k + 2));
      src(10'h3FF);
      chk({10'h000, greq}, 16'h0001 << k);
    end
    wrt(OFF_ENABLE, 16'h0000);
    src(10'h3FF);
    chk({10'h000, greq}, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      c3 = c[2:0];
      wrt(OFF_PRIORITY, {1'b1, c3, 1'b1, c3, 1'b1, c3, 1'b1, c3});
      rdc(OFF_PRIORITY, {4{1'b0, c3}});
      chk({4'h0, lvl}, {4'h0, {4{c3}}});
      chk({12'h000, preq}, c3 != 3'h0 ? 16'h000F : 16'h0000);
    end
    rdc(OFF_REQ_VIEW, 16'h03C0);
    src(10'h000);
    chk({12'h000, preq}, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    wrt(OFF_IRQ_MASK, 16'hFFFF);
    rdc(OFF_IRQ_MASK, 16'h03FF);
    chk({15'h0000, irq}, 16'h0001);
    rdc(OFF_IRQ_STATUS, 16'h03FF);
    wrt(OFF_IRQ_STATUS, 16'h03FF);
    rdc(OFF_IRQ_STATUS, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    rdc(4'hF, 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
